//--- rtl/sssr_top.sv
// Status byte, standard event register, enable masks and service request.
// Assumes synchronous command strobes from a command parser and a bus interface.
`timescale 1ns/100ps

module sssr_top
(
   input  wire logic        REF_CLK,
   input  wire logic        RSTN,
   input  wire logic [15:0] OPER_EVENT_SET,
   input  wire logic [15:0] QUES_EVENT_SET,
   input  wire logic [15:0] DEV_EVENT_SET,
   input  wire logic        OPER_QUERY,
   input  wire logic        QUES_QUERY,
   input  wire logic        DEV_QUERY,
   input  wire logic        OPER_ENA_WR,
   input  wire logic        QUES_ENA_WR,
   input  wire logic        DEV_ENA_WR,
   input  wire logic [15:0] ENA_WDATA,
   output logic      [15:0] OPER_EVENT,
   output logic      [15:0] QUES_EVENT,
   output logic      [15:0] DEV_EVENT,
   input  wire logic        OPC_DONE,
   input  wire logic        QUERY_ERR,
   input  wire logic        DEVICE_ERR,
   input  wire logic        EXEC_ERR,
   input  wire logic        CMD_ERR,
   input  wire logic        USER_REQ,
   input  wire logic        CLEAR_STATUS,
   input  wire logic        SEV_QUERY,
   output logic      [7:0]  SEV_DATA,
   input  wire logic        SEV_ENA_WR,
   input  wire logic        SRE_WR,
   input  wire logic [7:0]  MASK_WDATA,
   output logic      [7:0]  SEV_ENA,
   output logic      [7:0]  SRE_ENA,
   input  wire logic        OUTQ_NOT_EMPTY,
   input  wire logic        ERRQ_NOT_EMPTY,
   input  wire logic        STB_QUERY,
   input  wire logic        PRIOR_BUSY,
   output logic             STB_VALID,
   output logic      [7:0]  STB_DATA,
   input  wire logic        SPOLL,
   output logic      [7:0]  SPOLL_DATA,
   output logic             SRQ
);
   import sssr_pkg::*;

   logic [15:0]  oper_q, ques_q, dev_q;
   logic [15:0]  oper_en_q, ques_en_q, dev_en_q;
   logic [7:0]   sev_q, sev_en_q, sre_q, stb_q, spoll_q;
   logic         pon_q, rqs_ack_q, stb_v_q;
   sssr_qry_type qst_q, qst_d;

   wire         oper_sum = |(oper_q & oper_en_q);
   wire         ques_sum = |(ques_q & ques_en_q);
   wire         dev_sum  = |(dev_q & dev_en_q);
   wire         sev_sum  = |(sev_q & sev_en_q);
   wire  [7:0]  sum_bits = {oper_sum, 1'b0, sev_sum, OUTQ_NOT_EMPTY, ques_sum,
                            ERRQ_NOT_EMPTY, dev_sum, 1'b0};
   wire         mss      = |(sum_bits & sre_q);
   wire  [7:0]  stb_now  = sum_bits | ({7'h00, mss} << STB_RQS_BIT);
   wire  [7:0]  sev_hit  = {1'b0, USER_REQ, CMD_ERR, EXEC_ERR, DEVICE_ERR, QUERY_ERR,
                            1'b0, OPC_DONE};
   wire         sev_clr  = CLEAR_STATUS | SEV_QUERY;
   wire  [15:0] ena_w    = ENA_WDATA & WORD_TOP_MASK;

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         oper_q <= WORD_RESET;
         ques_q <= WORD_RESET;
         dev_q  <= WORD_RESET;
      end
      else
      begin
         // Set wins over clear; query and clear-status empty the group
         oper_q <= ((OPER_QUERY | CLEAR_STATUS) ? WORD_RESET : oper_q)
                   | (OPER_EVENT_SET & WORD_TOP_MASK);
         ques_q <= ((QUES_QUERY | CLEAR_STATUS) ? WORD_RESET : ques_q)
                   | (QUES_EVENT_SET & WORD_TOP_MASK);
         dev_q  <= ((DEV_QUERY | CLEAR_STATUS) ? WORD_RESET : dev_q)
                   | (DEV_EVENT_SET & WORD_TOP_MASK);
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         oper_en_q <= WORD_RESET;
         ques_en_q <= WORD_RESET;
         dev_en_q  <= WORD_RESET;
      end
      else
      begin
         if (OPER_ENA_WR)
            oper_en_q <= ena_w;
         if (QUES_ENA_WR)
            ques_en_q <= ena_w;
         if (DEV_ENA_WR)
            dev_en_q  <= ena_w;
      end
   end

   // Power-on flag survives until the first read or clear
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pon_q <= 1'b1;
         sev_q <= BYTE_RESET;
      end
      else
      begin
         pon_q <= 1'b0;
         sev_q <= ((sev_clr ? BYTE_RESET : sev_q) | sev_hit
                   | ({7'h00, pon_q} << SEV_PON_BIT)) & SEV_MASK;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         sev_en_q <= BYTE_RESET;
         sre_q    <= BYTE_RESET;
      end
      else
      begin
         if (SEV_ENA_WR)
            sev_en_q <= MASK_WDATA;
         if (SRE_WR)
            sre_q    <= MASK_WDATA & STB_SRE_MASK;
      end
   end

   // Serial poll: RQS is reported once per service request, then held off
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rqs_ack_q <= 1'b0;
         spoll_q   <= BYTE_RESET;
      end
      else
      begin
         if (!mss)
            rqs_ack_q <= 1'b0;
         else if (SPOLL)
            rqs_ack_q <= 1'b1;
         if (SPOLL)
            spoll_q <= stb_now & ~({7'h00, rqs_ack_q} << STB_RQS_BIT);
      end
   end

   // Status byte query waits for earlier commands in the queue
   always_comb
   begin
      qst_d = qst_q;
      case (qst_q)
         SSSR_IDLE_ST:
         begin
            if (STB_QUERY)
               qst_d = PRIOR_BUSY ? SSSR_WAIT_ST : SSSR_ANS_ST;
         end
         SSSR_WAIT_ST:
         begin
            if (!PRIOR_BUSY)
               qst_d = SSSR_ANS_ST;
         end
         SSSR_ANS_ST:
         begin
            qst_d = SSSR_IDLE_ST;
         end
         default:
         begin
            qst_d = SSSR_IDLE_ST;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         qst_q   <= SSSR_IDLE_ST;
         stb_q   <= BYTE_RESET;
         stb_v_q <= 1'b0;
      end
      else
      begin
         qst_q   <= qst_d;
         stb_v_q <= (qst_d == SSSR_ANS_ST);
         if (qst_d == SSSR_ANS_ST)
            stb_q <= stb_now;
      end
   end

   assign OPER_EVENT = oper_q;
   assign QUES_EVENT = ques_q;
   assign DEV_EVENT  = dev_q;
   assign SEV_DATA   = sev_q;
   assign SEV_ENA    = sev_en_q;
   assign SRE_ENA    = sre_q;
   assign STB_DATA   = stb_q;
   assign STB_VALID  = stb_v_q;
   assign SPOLL_DATA = spoll_q;
   assign SRQ        = mss;

   top_zero_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !oper_q[15] && !ques_q[15] && !dev_q[15])
      else $error("top bit set");
   ena_top_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !oper_en_q[15] && !ques_en_q[15] && !dev_en_q[15])
      else $error("enable top bit set");
   cls_groups_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      CLEAR_STATUS && (OPER_EVENT_SET | QUES_EVENT_SET | DEV_EVENT_SET) == WORD_RESET
      |=> OPER_EVENT == WORD_RESET && QUES_EVENT == WORD_RESET && DEV_EVENT == WORD_RESET)
      else $error("groups not cleared");
   oper_qry_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      OPER_QUERY && OPER_EVENT_SET == WORD_RESET |=> !oper_sum)
      else $error("oper sum stays");
   ques_qry_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      QUES_QUERY && QUES_EVENT_SET == WORD_RESET |=> !ques_sum)
      else $error("ques sum stays");
   dev_qry_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      DEV_QUERY && DEV_EVENT_SET == WORD_RESET |=> !dev_sum)
      else $error("dev sum stays");

   // The power-on bit may land on the first edge even while a clear is seen
   sev_clear_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      sev_clr && sev_hit == 8'h00 && !pon_q |=> sev_q == BYTE_RESET)
      else $error("sev not cleared");
   sev_unused_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !sev_q[SEV_UNU_BIT])
      else $error("sev bit1 set");
   opc_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      OPC_DONE |=> sev_q[SEV_OPC_BIT])
      else $error("opc lost");
   qry_err_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      QUERY_ERR |=> sev_q[SEV_QYE_BIT])
      else $error("query err lost");
   dev_err_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      DEVICE_ERR |=> sev_q[SEV_DDE_BIT])
      else $error("device err lost");
   exe_err_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      EXEC_ERR |=> sev_q[SEV_EXE_BIT])
      else $error("exec err lost");
   sev_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      CMD_ERR |=> sev_q[SEV_CME_BIT])
      else $error("cmd err lost");
   user_req_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      USER_REQ |=> sev_q[SEV_URQ_BIT])
      else $error("user req lost");
   pon_set_a: assert property (@(posedge REF_CLK)
      $rose(RSTN) |=> sev_q[SEV_PON_BIT])
      else $error("pon missing");
   sev_ena_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !SEV_ENA_WR |=> SEV_ENA == $past(SEV_ENA))
      else $error("sev enable changed");

   sre_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !SRE_WR |=> sre_q == $past(sre_q))
      else $error("sre changed");
   sre_zero_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SRE_WR && MASK_WDATA == BYTE_RESET |=> SRE_ENA == BYTE_RESET)
      else $error("sre not cleared");
   srq_out_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SRQ == |({oper_sum, sev_sum, OUTQ_NOT_EMPTY, ques_sum, ERRQ_NOT_EMPTY, dev_sum}
      & {sre_q[7], sre_q[5:1]}))
      else $error("srq wrong");

   stb_zero_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !STB_DATA[0] && !SPOLL_DATA[0])
      else $error("bit0 set");
   rqs_first_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL && mss && !rqs_ack_q |=> SPOLL_DATA[STB_RQS_BIT])
      else $error("rqs not reported");
   rqs_once_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL && rqs_ack_q |=> !SPOLL_DATA[STB_RQS_BIT])
      else $error("rqs reported twice");
   poll_errq_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL |=> SPOLL_DATA[STB_EEQ_BIT] == $past(ERRQ_NOT_EMPTY))
      else $error("poll errq wrong");
   poll_mav_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL |=> SPOLL_DATA[STB_MAV_BIT] == $past(OUTQ_NOT_EMPTY))
      else $error("poll mav wrong");
   poll_oper_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL |=> SPOLL_DATA[STB_OPER_BIT] == $past(|(oper_q & oper_en_q)))
      else $error("poll oper wrong");
   poll_ques_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL |=> SPOLL_DATA[STB_QUES_BIT] == $past(|(ques_q & ques_en_q)))
      else $error("poll ques wrong");
   poll_dev_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL |=> SPOLL_DATA[STB_DEV_BIT] == $past(|(dev_q & dev_en_q)))
      else $error("poll dev wrong");
   poll_sev_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SPOLL |=> SPOLL_DATA[STB_ESB_BIT] == $past(|(SEV_DATA & SEV_ENA)))
      else $error("poll sev wrong");

   mav_now_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      STB_QUERY && !PRIOR_BUSY && qst_q == SSSR_IDLE_ST
      |=> STB_DATA[STB_MAV_BIT] == $past(OUTQ_NOT_EMPTY))
      else $error("mav wrong");
   stb_live_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      qst_d == SSSR_ANS_ST |=> STB_DATA[STB_RQS_BIT] == $past(mss))
      else $error("stb rqs wrong");
   stb_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      STB_VALID |=> !STB_VALID)
      else $error("stb valid too long");
   stb_wait_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      qst_q == SSSR_WAIT_ST && PRIOR_BUSY |=> !STB_VALID)
      else $error("stb early");
   stb_busy_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      qst_q == SSSR_IDLE_ST && STB_QUERY && PRIOR_BUSY |=> !STB_VALID)
      else $error("stb ahead of busy");

   stb_ans_c: cover property (@(posedge REF_CLK) disable iff (!RSTN)
      qst_q == SSSR_WAIT_ST ##[1:20] STB_VALID);
   srq_c: cover property (@(posedge REF_CLK) disable iff (!RSTN) $rose(SRQ));
   spoll_c: cover property (@(posedge REF_CLK) disable iff (!RSTN) SPOLL && mss ##1 SPOLL);
   sev_sum_c: cover property (@(posedge REF_CLK) disable iff (!RSTN) $rose(sev_sum));
   cls_srq_c: cover property (@(posedge REF_CLK) disable iff (!RSTN) CLEAR_STATUS && mss);
endmodule

//--- rtl/sssr_pkg.sv
// Package for the status summary and service request block.
// Assumes a single 25 MHz clock domain and a command decoder feeding strobes.
package sssr_pkg;
   localparam int STB_DEV_BIT  = 1;
   localparam int STB_EEQ_BIT  = 2;
   localparam int STB_QUES_BIT = 3;
   localparam int STB_MAV_BIT  = 4;
   localparam int STB_ESB_BIT  = 5;
   localparam int STB_RQS_BIT  = 6;
   localparam int STB_OPER_BIT = 7;
   localparam int SEV_OPC_BIT  = 0;
   localparam int SEV_UNU_BIT  = 1;
   localparam int SEV_QYE_BIT  = 2;
   localparam int SEV_DDE_BIT  = 3;
   localparam int SEV_EXE_BIT  = 4;
   localparam int SEV_CME_BIT  = 5;
   localparam int SEV_URQ_BIT  = 6;
   localparam int SEV_PON_BIT  = 7;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   localparam logic [15:0] WORD_TOP_MASK = 16'h7FFF;
   localparam logic [7:0]  SEV_MASK      = 8'hFD;
   localparam logic [7:0]  STB_SRE_MASK  = 8'hBF;
   typedef enum logic [1:0] {
      SSSR_IDLE_ST = 2'b00,
      SSSR_WAIT_ST = 2'b01,
      SSSR_ANS_ST  = 2'b11
   } sssr_qry_type;
endpackage

//--- testbench/sssr_ctl_model.sv
// Bus controller model: issues serial polls and status byte queries.
// Assumes the caller runs in step with the falling clock edge.
`timescale 1ns/100ps
module sssr_ctl_model
(
   input  wire logic clk,
   output logic      spoll,
   output logic      stb_query
);
   initial
   begin
      spoll = 1'b0;
      stb_query = 1'b0;
   end
   // Each request is held from one falling edge to the next
   task automatic poll();
      @(negedge clk);
      spoll = 1'b1;
      @(negedge clk);
      spoll = 1'b0;
   endtask
   task automatic ask_stb();
      @(negedge clk);
      stb_query = 1'b1;
      @(negedge clk);
      stb_query = 1'b0;
   endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the status summary block.
// Assumes the package, the design and the controller model are compiled first.
`timescale 1ns/100ps
module tb_top;
   import sssr_pkg::*;
   logic        REF_CLK = 1'b0, RSTN = 1'b0, OUTQ_NOT_EMPTY = 1'b0, ERRQ_NOT_EMPTY = 1'b0;
   logic        PRIOR_BUSY = 1'b0, SPOLL, STB_QUERY, STB_VALID, SRQ, er;
   logic [5:0]  ctl = '0, sev_in = '0;
   logic [1:0]  gq = '0;
   logic [15:0] grp_set = '0, ENA_WDATA = '0, OPER_EVENT, QUES_EVENT, DEV_EVENT, e, s;
   logic [7:0]  MASK_WDATA = '0, SEV_DATA, SEV_ENA, SRE_ENA, STB_DATA, SPOLL_DATA, stb;
   logic [7:0]  expq[$];
   int          mismatches = 0, n_tests = 0;
   always #20 REF_CLK = ~REF_CLK;
   sssr_top dut_u (.REF_CLK, .RSTN, .OPER_EVENT_SET(grp_set), .QUES_EVENT_SET(grp_set),
      .DEV_EVENT_SET(grp_set), .OPER_QUERY(ctl[5]), .QUES_QUERY(ctl[5] | gq[0]),
      .DEV_QUERY(ctl[5] | gq[1]),
      .OPER_ENA_WR(ctl[4]), .QUES_ENA_WR(ctl[4]), .DEV_ENA_WR(ctl[4]), .ENA_WDATA, .OPER_EVENT,
      .QUES_EVENT, .DEV_EVENT, .OPC_DONE(sev_in[0]), .QUERY_ERR(sev_in[1]),
      .DEVICE_ERR(sev_in[2]), .EXEC_ERR(sev_in[3]), .CMD_ERR(sev_in[4]), .USER_REQ(sev_in[5]),
      .CLEAR_STATUS(ctl[0]), .SEV_QUERY(ctl[1]), .SEV_DATA, .SEV_ENA_WR(ctl[2]),
      .SRE_WR(ctl[3]), .MASK_WDATA, .SEV_ENA, .SRE_ENA, .OUTQ_NOT_EMPTY, .ERRQ_NOT_EMPTY,
      .STB_QUERY, .PRIOR_BUSY, .STB_VALID, .STB_DATA, .SPOLL, .SPOLL_DATA, .SRQ);
   sssr_ctl_model ctl_u (.clk(REF_CLK), .spoll(SPOLL), .stb_query(STB_QUERY));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge REF_CLK);
   endtask
   task automatic pulse(input logic [5:0] c, input logic [5:0] ev, input logic [15:0] st);
      ctl = c;
      sev_in = ev;
      grp_set = st;
      tick(1);
      ctl = '0;
      sev_in = '0;
      grp_set = '0;
      tick(1);
   endtask
   task automatic stb_ask(input logic [7:0] exp);
      expq.push_back(exp);
      ctl_u.ask_stb();
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic drain();
      for (int i = 0; i < 20 && expq.size() > 0; i++)
         tick(1);
      if (expq.size() > 0)
         chk("answer timeout", 16'h0000, 16'h0001);
   endtask
   // Answers are matched in order against the oldest outstanding query
   always @(negedge REF_CLK)
      if (STB_VALID === 1'b1)
      begin
         if (expq.size() == 0)
            chk("spare answer", 16'h0000, 16'h0001);
         else
            chk("status byte", {8'h00, expq.pop_front()}, {8'h00, STB_DATA});
      end
   initial
   begin
      void'($urandom(32'h5E284CA4));
      tick(12);
      RSTN = 1'b1;
      tick(2);
      chk("power-on event", 16'h0080, {8'h00, SEV_DATA});
      chk("request mask", 16'h0000, {8'h00, SRE_ENA});
      MASK_WDATA = 8'h20;
      pulse(6'h04, 6'h00, 16'h0000);
      pulse(6'h00, 6'h3F, 16'h0000);
      chk("event mask", 16'h0020, {8'h00, SEV_ENA});
      chk("standard events", 16'h00FD, {8'h00, SEV_DATA});
      stb_ask(8'h20);
      tick(1);
      pulse(6'h02, 6'h00, 16'h0000);
      chk("after event query", 16'h0000, {8'h00, SEV_DATA});
      stb_ask(8'h00);
      er = 1'($urandom());
      e = 16'($urandom()) | 16'h0001;
      s = 16'($urandom()) | 16'h8001;
      OUTQ_NOT_EMPTY = 1'b1;
      ERRQ_NOT_EMPTY = er;
      ENA_WDATA = e;
      pulse(6'h10, 6'h00, s);
      chk("operation events", s & 16'h7FFF, OPER_EVENT);
      chk("questionable events", s & 16'h7FFF, QUES_EVENT);
      chk("device events", s & 16'h7FFF, DEV_EVENT);
      stb = {5'b10011, er, 2'b10};
      stb_ask(stb);
      tick(1);
      MASK_WDATA = 8'h10;
      pulse(6'h08, 6'h00, 16'h0000);
      chk("request line", 16'h0001, {15'h0, SRQ});
      PRIOR_BUSY = 1'b1;
      stb_ask(stb | 8'h40);
      for (int i = 0; i < 3; i++)
      begin
         chk("early answer", 16'h0000, {15'h0, STB_VALID});
         tick(1);
      end
      PRIOR_BUSY = 1'b0;
      drain();
      ctl_u.poll();
      chk("serial poll", {8'h00, stb | 8'h40}, {8'h00, SPOLL_DATA});
      tick(1);
      ctl_u.poll();
      chk("repeat poll", {8'h00, stb}, {8'h00, SPOLL_DATA});
      gq = 2'b01;
      tick(1);
      gq = 2'b00;
      stb_ask((stb | 8'h40) & 8'hF7);
      gq = 2'b10;
      tick(1);
      gq = 2'b00;
      stb_ask((stb | 8'h40) & 8'hF5);
      chk("device events", 16'h0000, DEV_EVENT);
      MASK_WDATA = 8'h00;
      OUTQ_NOT_EMPTY = 1'b0;
      pulse(6'h29, 6'h00, 16'h0000);
      chk("cleared events", 16'h0000, OPER_EVENT);
      chk("request mask", 16'h0000, {8'h00, SRE_ENA});
      chk("request line", 16'h0000, {15'h0, SRQ});
      stb_ask({5'b00000, er, 2'b00});
      drain();
      RSTN = 1'b0;
      tick(2);
      RSTN = 1'b1;
      tick(2);
      chk("reset events", 16'h0080, {8'h00, SEV_DATA});
      chk("reset event mask", 16'h0000, {8'h00, SEV_ENA});
      final_report();
   end
endmodule
